/* File: logic/spi_rate_flags.sv */
`timescale 1ns/1ps
// Behaviour
// - bit rate register accessible at any time
// - prescale field bits 6:4 divides by value+1
// - rate field bits 2:0 divides by 2..256
// - status holds three read-only flags, writes ignored
// - status bits 6,3,2,1,0 read zero
// - receive-full set when transfer completes
// - receive-full cleared by status read, data read
// - transmit-empty cleared by status read, data write
// - data write without armed status read discarded
// - transmit irq when flag and enable set
// - transmit-empty set on buffer to shifter move
// - idle master: byte moves, flag back within two cycles
// - queued byte follows completed shift automatically
// - mode fault set when select input low
// - fault input only master, fault enable, no output
// - mode fault cleared by status read, control write
// - receive/fault irq on either flag when enabled
// - disable halts transfer, flushes, resets receive-full and transmit-empty flags; mode fault kept
// - receive overrun loses data without indication
module spi_rate_flags (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [spi_rate_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// serial pins
	output logic sck,
	output logic mosi,
	input wire logic miso,
	input wire logic ss_n_in,
	output logic ss_n_out,
	output logic ss_oe,
	// interrupt requests
	output logic tx_irq,
	output logic rx_fault_irq
);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	spi_rate_pkg::control1_s control1;
	spi_rate_pkg::frame_format_s fmt;
	logic fault_function_enable;
	logic [7:0] bit_rate;
	logic [7:0] tx_buf;
	logic [7:0] rx_buf;
	logic receive_full_flag;
	logic transmit_empty_flag;
	logic mode_fault_flag;
	logic rx_armed;
	logic tx_armed;
	logic fault_armed;
	logic [7:0] status_value;
	logic [7:0] read_value;
	logic access;
	logic wr_access;
	logic rd_access;
	logic wr_control1;
	logic wr_control2;
	logic wr_bit_rate;
	logic wr_data;
	logic rd_status;
	logic rd_data;
	logic tx_accept;
	logic enabled;
	logic is_master;
	logic fault_input_active;
	logic shift_start;
	logic shift_busy;
	logic shift_done;
	logic [7:0] shift_rx;
	logic half_tick;
	logic shifter_sck;
	logic shifter_mosi;

	// true for the five mapped word addresses only
	function automatic logic addr_mapped(input logic [spi_rate_pkg::ADDR_W-1:0] addr);
		addr_mapped = (addr == spi_rate_pkg::OFF_CONTROL1) ||
			(addr == spi_rate_pkg::OFF_CONTROL2) ||
			(addr == spi_rate_pkg::OFF_BIT_RATE) ||
			(addr == spi_rate_pkg::OFF_STATUS) ||
			(addr == spi_rate_pkg::OFF_DATA);
	endfunction

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	// access completes at the edge where pready is seen; unmapped ones do nothing
	assign access = psel && penable && pready && !pslverr;
	assign wr_access = access && pwrite;
	assign rd_access = access && !pwrite;
	assign wr_control1 = wr_access && (paddr == spi_rate_pkg::OFF_CONTROL1);
	assign wr_control2 = wr_access && (paddr == spi_rate_pkg::OFF_CONTROL2);
	assign wr_bit_rate = wr_access && (paddr == spi_rate_pkg::OFF_BIT_RATE);
	assign wr_data = wr_access && (paddr == spi_rate_pkg::OFF_DATA);
	assign rd_status = rd_access && (paddr == spi_rate_pkg::OFF_STATUS);
	assign rd_data = rd_access && (paddr == spi_rate_pkg::OFF_DATA);

	// ----------------------------------------
	// mode decode
	// ----------------------------------------
	assign enabled = control1.interface_enable;
	assign is_master = control1.master_select;
	assign fmt = '{clock_polarity: control1.clock_polarity,
		clock_phase: control1.clock_phase,
		lsb_first: control1.lsb_first};
	// select pin is a fault input only in this one configuration
	assign fault_input_active = enabled && is_master && fault_function_enable &&
		!control1.select_output_enable;

	// status image: three flags, unused positions tied low
	always_comb begin
		status_value = 8'h00;
		status_value[spi_rate_pkg::STATUS_RX_FULL_BIT] = receive_full_flag;
		status_value[spi_rate_pkg::STATUS_TX_EMPTY_BIT] = transmit_empty_flag;
		status_value[spi_rate_pkg::STATUS_MODE_FAULT_BIT] = mode_fault_flag;
	end

	// read mux; data port returns the receive buffer
	always_comb begin
		read_value = 8'h00;
		unique case (paddr)
			spi_rate_pkg::OFF_CONTROL1: read_value = control1;
			spi_rate_pkg::OFF_CONTROL2: read_value = {3'h0, fault_function_enable, 4'h0};
			spi_rate_pkg::OFF_BIT_RATE: read_value = bit_rate & spi_rate_pkg::BIT_RATE_MASK;
			spi_rate_pkg::OFF_STATUS: read_value = status_value;
			spi_rate_pkg::OFF_DATA: read_value = rx_buf;
			default: read_value = 8'h00;
		endcase
	end

	// ----------------------------------------
	// apb answer: no wait state, all from flops
	// ----------------------------------------
	// read data is frozen in the setup cycle, so the value seen is the one the
	// flag arming below is based on, even if a flag moves during the access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel && !penable;
			if (psel && !penable) begin
				pslverr <= !addr_mapped(paddr);
				prdata <= {24'h00_0000, pwrite ? 8'h00 : read_value};
			end else begin
				pslverr <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	// first control register, plain read/write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			control1 <= spi_rate_pkg::CONTROL1_RESET;
		end else if (wr_control1) begin
			control1 <= pwdata[7:0];
		end
	end

	// second control register holds only the fault enable here
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_function_enable <= spi_rate_pkg::CONTROL2_RESET[spi_rate_pkg::CONTROL2_FAULT_EN_BIT];
		end else if (wr_control2) begin
			fault_function_enable <= pwdata[spi_rate_pkg::CONTROL2_FAULT_EN_BIT];
		end
	end

	// bit rate register; a change mid-byte takes effect on the next count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bit_rate <= spi_rate_pkg::BIT_RATE_RESET;
		end else if (wr_bit_rate) begin
			bit_rate <= pwdata[7:0] & spi_rate_pkg::BIT_RATE_MASK;
		end
	end

	// ----------------------------------------
	// flag arming from status reads
	// ----------------------------------------
	// status writes fall through here untouched: no flag moves on them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_armed <= 1'b0;
		end else if (!enabled) begin
			rx_armed <= 1'b0;
		end else if (rd_status && prdata[spi_rate_pkg::STATUS_RX_FULL_BIT]) begin
			rx_armed <= 1'b1;
		end else if (rd_data) begin
			rx_armed <= 1'b0;
		end
	end

	// transmit arming; only a read that saw the flag high counts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_armed <= 1'b0;
		end else if (!enabled) begin
			tx_armed <= 1'b0;
		end else if (rd_status && prdata[spi_rate_pkg::STATUS_TX_EMPTY_BIT]) begin
			tx_armed <= 1'b1;
		end else if (wr_data) begin
			tx_armed <= 1'b0;
		end
	end

	// fault arming survives disable; the fault flag itself does too
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_armed <= 1'b0;
		end else if (rd_status && prdata[spi_rate_pkg::STATUS_MODE_FAULT_BIT]) begin
			fault_armed <= 1'b1;
		end else if (wr_control1) begin
			fault_armed <= 1'b0;
		end
	end

	// ----------------------------------------
	// transmit buffer
	// ----------------------------------------
	// a data write without a preceding armed status read is simply dropped
	assign tx_accept = wr_data && tx_armed && transmit_empty_flag && enabled;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_buf <= 8'h00;
		end else if (tx_accept) begin
			tx_buf <= pwdata[7:0];
		end
	end

	// as master, a queued byte enters an idle shifter on the cycle after the write
	assign shift_start = enabled && is_master && !shift_busy && !transmit_empty_flag;

	// empty flag: disable and buffer-to-shifter move set it, accepted write clears
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			transmit_empty_flag <= 1'b1;
		end else if (!enabled) begin
			transmit_empty_flag <= 1'b1;
		end else if (shift_start) begin
			transmit_empty_flag <= 1'b1;
		end else if (tx_accept) begin
			transmit_empty_flag <= 1'b0;
		end
	end

	// ----------------------------------------
	// receive buffer and full flag
	// ----------------------------------------
	// an unread byte is kept; the newer one is lost with no flag raised
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_buf <= 8'h00;
		end else if (shift_done && !receive_full_flag) begin
			rx_buf <= shift_rx;
		end
	end

	// completion wins over a clearing data read in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			receive_full_flag <= 1'b0;
		end else if (!enabled) begin
			receive_full_flag <= 1'b0;
		end else if (shift_done) begin
			receive_full_flag <= 1'b1;
		end else if (rd_data && rx_armed) begin
			receive_full_flag <= 1'b0;
		end
	end

	// ----------------------------------------
	// mode fault
	// ----------------------------------------
	// a low select input while set up as fault-checking master means contention
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_fault_flag <= 1'b0;
		end else if (fault_input_active && !ss_n_in) begin
			mode_fault_flag <= 1'b1;
		end else if (wr_control1 && fault_armed) begin
			mode_fault_flag <= 1'b0;
		end
	end

	// ----------------------------------------
	// interrupt requests
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_irq <= 1'b0;
			rx_fault_irq <= 1'b0;
		end else begin
			tx_irq <= transmit_empty_flag && control1.transmit_irq_enable;
			rx_fault_irq <= control1.receive_fault_irq_enable &&
				(receive_full_flag || mode_fault_flag);
		end
	end

	// ----------------------------------------
	// automatic select output
	// ----------------------------------------
	// driven only as master with fault enable and select output both set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ss_oe <= 1'b0;
			ss_n_out <= 1'b1;
		end else begin
			ss_oe <= enabled && is_master && fault_function_enable &&
				control1.select_output_enable;
			ss_n_out <= !(shift_busy || shift_start);
		end
	end

	// ----------------------------------------
	// bit clock and shifter
	// ----------------------------------------
	// counters only run during a byte so every byte starts on a clean period
	bit_rate_gen #(
		.SEL_W(spi_rate_pkg::SEL_W)
	) u_rate (
		.pclk(pclk),
		.presetn(presetn),
		.run(shift_busy),
		.prescale_select(bit_rate[spi_rate_pkg::PRESCALE_LSB +: spi_rate_pkg::SEL_W]),
		.rate_divider_select(bit_rate[spi_rate_pkg::RATE_LSB +: spi_rate_pkg::SEL_W]),
		.half_tick(half_tick)
	);

	// disable resets the shifter state in the same cycle
	byte_shifter u_shift (
		.pclk(pclk),
		.presetn(presetn),
		.clear(!enabled),
		.start(shift_start),
		.load_data(tx_buf),
		.half_tick(half_tick),
		.fmt(fmt),
		.miso(miso),
		.sck(shifter_sck),
		.mosi(shifter_mosi),
		.busy(shift_busy),
		.done(shift_done),
		.rx_data(shift_rx)
	);

	// pins come straight from the shifter flops
	assign sck = shifter_sck;
	assign mosi = shifter_mosi;

endmodule

/* File: logic/spi_rate_pkg.sv */
package spi_rate_pkg;

	// ----------------------------------------
	// register map, byte addresses on the apb
	// ----------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_CONTROL1 = 8'h00;
	localparam logic [7:0] OFF_CONTROL2 = 8'h04;
	localparam logic [7:0] OFF_BIT_RATE = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0c;
	localparam logic [7:0] OFF_DATA = 8'h10;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int PRESCALE_LSB = 4;
	localparam int RATE_LSB = 0;
	localparam int SEL_W = 3;
	localparam int STATUS_RX_FULL_BIT = 7;
	localparam int STATUS_TX_EMPTY_BIT = 5;
	localparam int STATUS_MODE_FAULT_BIT = 4;
	localparam int CONTROL2_FAULT_EN_BIT = 4;

	// ----------------------------------------
	// reset values and implemented-bit masks
	// ----------------------------------------
	localparam logic [7:0] CONTROL1_RESET = 8'h04;
	localparam logic [7:0] CONTROL2_RESET = 8'h00;
	localparam logic [7:0] BIT_RATE_RESET = 8'h00;
	localparam logic [7:0] BIT_RATE_MASK = 8'h77;
	localparam logic [7:0] CONTROL2_MASK = 8'h10;

	// ----------------------------------------
	// timing counts, in pclk cycles or sck edges
	// ----------------------------------------
	localparam int TX_LOAD_CYCLES = 2;
	localparam int EDGES_PER_BYTE = 16;
	localparam logic [3:0] LAST_EDGE = 4'hf;

	// ----------------------------------------
	// first control register layout, msb first
	// ----------------------------------------
	typedef struct packed {
		logic receive_fault_irq_enable;
		logic interface_enable;
		logic transmit_irq_enable;
		logic master_select;
		logic clock_polarity;
		logic clock_phase;
		logic select_output_enable;
		logic lsb_first;
	} control1_s;

	// ----------------------------------------
	// format settings handed to the shifter
	// ----------------------------------------
	typedef struct packed {
		logic clock_polarity;
		logic clock_phase;
		logic lsb_first;
	} frame_format_s;

endpackage

/* File: logic/bit_rate_gen.sv */
`timescale 1ns/1ps
module bit_rate_gen #(
	parameter int SEL_W = 3
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic run,
	input wire logic [SEL_W-1:0] prescale_select,
	input wire logic [SEL_W-1:0] rate_divider_select,
	// half bit period enable
	output logic half_tick
);

	// ----------------------------------------
	// prescaler and rate divider counters
	// ----------------------------------------
	logic [SEL_W-1:0] pre_count;
	logic [7:0] rate_count;
	logic pre_tick;
	logic [7:0] half_limit;

	// prescaler wraps after select+1 cycles, giving divide by 1..8
	assign pre_tick = (pre_count == prescale_select);
	// divider of 2^(sel+1) toggles sck every 2^sel prescaled ticks
	assign half_limit = 8'((9'h001 << rate_divider_select) - 9'h001);

	// prescaler count; restarts when idle so the first edge is a full half period away
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_count <= '0;
		end else if (!run || pre_tick) begin
			pre_count <= '0;
		end else begin
			pre_count <= pre_count + 1'b1;
		end
	end

	// rate divider count, stepped by prescaler output only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rate_count <= 8'h00;
		end else if (!run) begin
			rate_count <= 8'h00;
		end else if (pre_tick) begin
			rate_count <= (rate_count >= half_limit) ? 8'h00 : rate_count + 8'h01;
		end
	end

	// two half ticks per sck period: bit rate = pclk / (prescale * rate)
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			half_tick <= 1'b0;
		end else begin
			half_tick <= run && pre_tick && (rate_count >= half_limit);
		end
	end

endmodule

/* File: logic/byte_shifter.sv */
`timescale 1ns/1ps
module byte_shifter (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic clear,
	input wire logic start,
	input wire logic [7:0] load_data,
	input wire logic half_tick,
	input wire spi_rate_pkg::frame_format_s fmt,
	// serial pins
	input wire logic miso,
	output logic sck,
	output logic mosi,
	// status
	output logic busy,
	output logic done,
	output logic [7:0] rx_data
);

	typedef enum logic {IDLE, SHIFTING} shift_state_e;

	shift_state_e state;
	logic [7:0] shreg;
	logic [7:0] next_shreg;
	logic [3:0] edge_count;
	logic sample_bit;
	logic sample_edge;

	// shift one position, entering the sampled bit at the far end
	function automatic logic [7:0] shift_in(input logic [7:0] value, input logic bit_in,
			input logic lsb_first);
		shift_in = lsb_first ? {bit_in, value[7:1]} : {value[6:0], bit_in};
	endfunction

	// ----------------------------------------
	// edge classification and next shift value
	// ----------------------------------------
	assign sample_edge = (edge_count[0] == fmt.clock_phase);

	// phase 1 presents the first bit on edge 0, so that edge moves nothing
	always_comb begin
		next_shreg = shreg;
		if (state == IDLE) begin
			if (start) begin
				next_shreg = load_data;
			end
		end else if (half_tick && !sample_edge) begin
			if (!(fmt.clock_phase && edge_count == 4'h0)) begin
				next_shreg = shift_in(shreg, sample_bit, fmt.lsb_first);
			end
		end
	end

	// ----------------------------------------
	// transfer sequencer
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= IDLE;
			shreg <= 8'h00;
			edge_count <= 4'h0;
			sample_bit <= 1'b0;
			sck <= 1'b0;
			done <= 1'b0;
			rx_data <= 8'h00;
		end else if (clear) begin
			state <= IDLE; // disable aborts mid-byte
			edge_count <= 4'h0;
			sck <= fmt.clock_polarity;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			shreg <= next_shreg;
			unique case (state)
				IDLE: begin
					sck <= fmt.clock_polarity;
					if (start) begin
						edge_count <= 4'h0;
						state <= SHIFTING;
					end
				end
				SHIFTING: begin
					if (half_tick) begin
						sck <= ~sck;
						edge_count <= edge_count + 4'h1;
						if (sample_edge) begin
							sample_bit <= miso;
						end
						if (edge_count == spi_rate_pkg::LAST_EDGE) begin
							state <= IDLE;
							done <= 1'b1;
							rx_data <= shift_in(shreg, fmt.clock_phase ? miso : sample_bit,
								fmt.lsb_first);
						end
					end
				end
			endcase
		end
	end

	// data pin follows the outgoing end of the shifter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mosi <= 1'b0;
		end else begin
			mosi <= fmt.lsb_first ? next_shreg[0] : next_shreg[7];
		end
	end

	assign busy = (state == SHIFTING);

endmodule

/* File: dv/spi_rate_flags_assertions.sv */
`timescale 1ns/1ps
module spi_rate_flags_assertions (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [spi_rate_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// interrupt requests
	input wire logic tx_irq,
	input wire logic rx_fault_irq
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// status read in its access cycle
	logic rd_st;
	assign rd_st = pready && !pwrite && paddr == spi_rate_pkg::OFF_STATUS;

	// ----------------------------------------
	// apb timing and register contents
	// ----------------------------------------
	a_ready_next: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	a_ready_cause: assert property (pready |-> $past(psel && !penable))
		else $error("pready without setup");
	a_err_unmapped: assert property (pready |->
		pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10}))
		else $error("pslverr wrong for address");
	a_rdata_hold: assert property ($changed(prdata) |-> $past(psel && !penable))
		else $error("prdata moved outside setup");
	a_status_zeros: assert property (rd_st |-> (prdata & 32'hffffff4f) == 32'h0)
		else $error("status unused bits set");
	a_rate_zeros: assert property (pready && !pwrite &&
		paddr == spi_rate_pkg::OFF_BIT_RATE |-> (prdata & 32'hffffff88) == 32'h0)
		else $error("bit rate unused bits set");
	// irq lags its flag by one cycle, as prdata lags the setup
	a_tx_irq_quiet: assert property (rd_st && !prdata[5] |-> !tx_irq)
		else $error("tx irq without empty flag");
	a_rx_irq_quiet: assert property (rd_st && !prdata[7] && !prdata[4] |-> !rx_fault_irq)
		else $error("rx fault irq without flag");
endmodule

bind spi_rate_flags spi_rate_flags_assertions spi_rate_flags_assertions_i (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.tx_irq(tx_irq), .rx_fault_irq(rx_fault_irq));

/* File: dv/spi_slave_model.sv */
`timescale 1ns/1ps
module spi_slave_model (
	// serial pins
	input wire logic sck,
	input wire logic mosi,
	input wire logic ss_n,
	output logic miso,
	// byte exchange with the bench
	input wire logic [7:0] tx_byte,
	output logic [7:0] rx_byte,
	output int nbytes
);
	logic [7:0] sh;
	int nb;
	initial begin
		miso = 1'b0;
		rx_byte = 8'h00;
		nbytes = 0;
		nb = 0;
	end
	// load on select so the first bit is out before any edge
	always @(negedge ss_n) begin
		sh = tx_byte;
		nb = 0;
		miso = sh[7];
	end
	// capture on rising sck, which suits clock modes 0 and 3
	always @(posedge sck) begin
		if (!ss_n) begin
			rx_byte = {rx_byte[6:0], mosi};
			nb++;
			if (nb == 8) nbytes++;
		end
	end
	// shift on falling sck, but not ahead of the first capture; select may stay low
	always @(negedge sck) begin
		if (!ss_n) begin
			sh = (nb == 8) ? tx_byte : (nb == 0) ? sh : {sh[6:0], 1'b0};
			if (nb == 8) nb = 0;
			miso = sh[7];
		end
	end
	// a released line must not look like the last bit
	always @(posedge ss_n) miso = ~miso;
endmodule

/* File: dv/test_spi_rate_flags.sv */
`timescale 1ns/1ps
module test_spi_rate_flags;
	typedef struct packed {
		logic [7:0] a;
		logic [31:0] d;
		logic [31:0] q;
		logic e;
	} row_s;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic ss_n_in = 1'b1;
	logic miso;
	logic [31:0] prdata;
	logic pready, pslverr, sck, mosi, ss_n_out, ss_oe, tx_irq, rx_fault_irq, ss_line;
	logic [7:0] slave_byte = 8'h00;
	logic [7:0] rx_byte;
	int nbytes, n0;
	int cyc = 0;
	int checks = 0;
	int n_mismatch = 0;
	// write, read back, expected value and error
	row_s rows [5] = '{'{8'h08, 32'hff, 32'h77, 1'b0}, '{8'h08, 32'h5a, 32'h52, 1'b0},
		'{8'h04, 32'hff, 32'h10, 1'b0}, '{8'h0c, 32'hff, 32'h20, 1'b0},
		'{8'h14, 32'hff, 32'h00, 1'b1}};

	always #2.5 pclk = ~pclk;
	// pulled up while the select output is not driven
	assign ss_line = ss_oe ? ss_n_out : 1'b1;

	spi_rate_flags spi_rate_flags_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sck(sck), .mosi(mosi), .miso(miso),
		.ss_n_in(ss_n_in), .ss_n_out(ss_n_out), .ss_oe(ss_oe), .tx_irq(tx_irq),
		.rx_fault_irq(rx_fault_irq));
	spi_slave_model spi_slave_model_i (.sck(sck), .mosi(mosi), .ss_n(ss_line), .miso(miso),
		.tx_byte(slave_byte), .rx_byte(rx_byte), .nbytes(nbytes));

	// ----------------------------------------
	// bus and check tasks
	// ----------------------------------------
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(a, 1'b1, d, q, e);
	endtask
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		checks++;
		if (g !== x) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] x);
		logic [31:0] q;
		logic e;
		apb(a, 1'b0, 32'h0, q, e);
		chk(n, x, q);
	endtask
	// armed write, then time the high half of sck and wait for the byte
	task automatic xfer(input logic [2:0] p, input logic [2:0] r, input logic [7:0] d,
		input logic [31:0] s);
		int h;
		slave_byte = ~d;
		wr(spi_rate_pkg::OFF_BIT_RATE, {25'h0, p, 1'b0, r});
		rdc("status_pre", spi_rate_pkg::OFF_STATUS, s);
		n0 = nbytes;
		wr(spi_rate_pkg::OFF_DATA, {24'h0, d});
		@(posedge sck);
		h = 0;
		do begin
			@(posedge pclk);
			h++;
		end while (sck === 1'b1);
		chk("sck_period", 32'((p + 1) * (2 << r)), 32'(2 * (h - 1)));
		while (nbytes == n0) @(posedge pclk);
		while (ss_n_out !== 1'b1) @(posedge pclk);
		repeat (2) @(posedge pclk);
		chk("slave_rx", {24'h0, d}, {24'h0, rx_byte});
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// watchdog, the whole run needs about 22000 cycles
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			n_mismatch++;
			report_and_stop();
		end
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] q;
		logic e;
		logic [7:0] d, ctl;
		logic [2:0] p, r;
		logic f;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rdc("ctl1_reset", spi_rate_pkg::OFF_CONTROL1, 32'h04);
		rdc("rate_reset", spi_rate_pkg::OFF_BIT_RATE, 32'h00);
		rdc("status_reset", spi_rate_pkg::OFF_STATUS, 32'h20);
		foreach (rows[i]) begin
			apb(rows[i].a, 1'b1, rows[i].d, q, e);
			apb(rows[i].a, 1'b0, 32'h0, q, e);
			chk("row_read", rows[i].q, q);
			chk("row_err", {31'h0, rows[i].e}, {31'h0, e});
		end
		$display("test registers done");
		wr(spi_rate_pkg::OFF_CONTROL1, 32'h52);
		for (int i = 0; i < 17; i++) begin
			d = 8'h81 ^ 8'(i * 37);
			p = 3'(i == 16 ? 7 : (i < 8 ? 0 : i));
			r = 3'(i == 16 ? 7 : (i < 8 ? i : 0));
			if (i == 15) wr(spi_rate_pkg::OFF_CONTROL1, 32'h7e); // mode 3
			xfer(p, r, d, 32'h20);
			rdc("status_full", spi_rate_pkg::OFF_STATUS, 32'ha0);
			rdc("rx_data", spi_rate_pkg::OFF_DATA, {24'h0, ~d});
			rdc("status_clear", spi_rate_pkg::OFF_STATUS, 32'h20);
		end
		$display("test rates done");
		// unarmed write is dropped, then an overrun keeps the old byte
		xfer(3'h0, 3'h0, 8'h3c, 32'h20);
		n0 = nbytes;
		wr(spi_rate_pkg::OFF_DATA, 32'h99);
		repeat (100) @(posedge pclk);
		chk("no_shift", 32'(n0), 32'(nbytes));
		xfer(3'h0, 3'h0, 8'h55, 32'ha0);
		rdc("status_ovr", spi_rate_pkg::OFF_STATUS, 32'ha0);
		rdc("rx_kept", spi_rate_pkg::OFF_DATA, 32'hc3);
		// second byte queued behind a running one
		wr(spi_rate_pkg::OFF_BIT_RATE, 32'h02);
		rdc("status_q0", spi_rate_pkg::OFF_STATUS, 32'h20);
		n0 = nbytes;
		wr(spi_rate_pkg::OFF_DATA, 32'h11);
		rdc("tx_back", spi_rate_pkg::OFF_STATUS, 32'h20);
		wr(spi_rate_pkg::OFF_DATA, 32'h22);
		rdc("tx_full", spi_rate_pkg::OFF_STATUS, 32'h00);
		while (nbytes < n0 + 2) @(posedge pclk);
		while (ss_n_out !== 1'b1) @(posedge pclk);
		repeat (2) @(posedge pclk);
		chk("queued_rx", 32'h22, {24'h0, rx_byte});
		rdc("status_q2", spi_rate_pkg::OFF_STATUS, 32'ha0);
		$display("test queue done");
		// rate change and disable in mid-transfer
		wr(spi_rate_pkg::OFF_BIT_RATE, 32'h77);
		rdc("status_d0", spi_rate_pkg::OFF_STATUS, 32'ha0);
		wr(spi_rate_pkg::OFF_DATA, 32'h5a);
		repeat (50) @(posedge pclk);
		wr(spi_rate_pkg::OFF_BIT_RATE, 32'h76);
		rdc("rate_busy", spi_rate_pkg::OFF_BIT_RATE, 32'h76);
		chk("ss_busy", 32'h0, {31'h0, ss_n_out});
		wr(spi_rate_pkg::OFF_CONTROL1, 32'h12);
		repeat (3) @(posedge pclk);
		chk("ss_idle", 32'h1, {31'h0, ss_n_out});
		rdc("status_off", spi_rate_pkg::OFF_STATUS, 32'h20);
		$display("test disable done");
		// every select configuration against a low select input
		for (int c = 0; c < 8; c++) begin
			ctl = {2'b11, c[2], c[2], 2'b00, c[0], 1'b0};
			f = c[2] & c[1] & ~c[0];
			wr(spi_rate_pkg::OFF_CONTROL2, {27'h0, c[1], 4'h0});
			wr(spi_rate_pkg::OFF_CONTROL1, {24'h0, ctl});
			ss_n_in <= 1'b0;
			repeat (4) @(posedge pclk);
			wr(spi_rate_pkg::OFF_CONTROL1, {24'h0, ctl});
			ss_n_in <= 1'b1;
			rdc("fault_set", spi_rate_pkg::OFF_STATUS, {26'h0, 1'b1, f, 4'h0});
			chk("tx_irq", {31'h0, c[2]}, {31'h0, tx_irq});
			chk("rxf_irq", {31'h0, f}, {31'h0, rx_fault_irq});
			chk("ss_oe", {31'h0, c == 7}, {31'h0, ss_oe});
			wr(spi_rate_pkg::OFF_CONTROL1, {24'h0, ctl});
			rdc("fault_clr", spi_rate_pkg::OFF_STATUS, 32'h20);
		end
		$display("test fault done");
		report_and_stop();
	end
endmodule
